// ---- udr_register_map.sv ----
`timescale 1ns/100ps
module udr_register_map
    import udr_pkg::*;
#(
    parameter int          EP_IDX_W = 5,
    parameter logic [23:0] PART_IDENTIFICATION  = 24'h5a0c3e  // arbitrary value
)(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        bus_cs_n,
    input  wire logic        bus_rd_n,
    input  wire logic        bus_wr_n,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [15:0] bus_data_in,
    input  wire logic        vbus_pin,
    input  wire logic        usb_bus_reset,
    input  wire logic        status_ack,
    input  wire logic        suspend_active,
    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame,
    input  wire logic [31:0] irq_events,
    output logic      [15:0] bus_data_out,
    output logic             bus_data_oe_n,
    output logic      [6:0]  usb_address_field,
    output logic             function_enable_bit,
    output logic      [15:0] mode_control,
    output logic             write_locked,
    output logic             soft_reset_pulse
);

    localparam int EP_N = 1 << EP_IDX_W;

    function automatic logic [31:0] put_half(input logic [31:0] old,
                                             input logic        hi,
                                             input logic [15:0] d);
        return hi ? {d, old[15:0]} : {old[31:16], d};
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    udr_bus_t    pin_now;
    udr_bus_t    bus_s1;
    udr_bus_t    bus_s2;
    udr_bus_t    bus_prev;
    logic        vbus_s1;
    logic        vbus_s2;
    logic        rst_all;
    logic        wr_ev;
    logic        wr_ok;
    logic        rd_act;
    logic [7:0]  wa;
    logic [15:0] wd;

    assign pin_now = '{addr: bus_addr, data: bus_data_in, cs: ~bus_cs_n,
                       rd: ~bus_rd_n, wr: ~bus_wr_n};

    // strobes pass the same two stages as data; host must hold data across them
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            bus_s1   <= '0;
            bus_s2   <= '0;
            bus_prev <= '0;
            vbus_s1  <= 1'b0;
            vbus_s2  <= 1'b0;
        end
        else
        begin
            bus_s1   <= pin_now;
            bus_s2   <= bus_s1;
            bus_prev <= bus_s2;
            vbus_s1  <= vbus_pin;
            vbus_s2  <= vbus_s1;
        end
    end

    assign rst_all = ~resetn | soft_reset_pulse;
    assign wa      = bus_s2.addr;
    assign wd      = bus_s2.data;
    assign rd_act  = bus_s2.cs & bus_s2.rd;
    assign wr_ev   = bus_s2.cs & bus_s2.wr & ~(bus_prev.cs & bus_prev.wr);
    assign wr_ok   = wr_ev & (~write_locked | (wa == OFS_UNLOCK));

    // ****************************************
    // address register
    // ****************************************
    logic [6:0] addr_pend;

    always_ff @(posedge clock)
    begin
        if (rst_all)
        begin
            addr_pend           <= RST_ADDR[6:0];
            usb_address_field   <= RST_ADDR[6:0];
            function_enable_bit <= RST_ADDR[ADDR_EN_BIT];
        end
        else
        begin
            if (usb_bus_reset)
            begin
                addr_pend         <= RST_ADDR[6:0];
                usb_address_field <= RST_ADDR[6:0];
            end
            else
            begin
                if (wr_ok && wa == OFS_ADDR)
                    addr_pend <= wd[6:0];
                // old address stays live until the empty status packet is acked
                if (status_ack)
                    usb_address_field <= addr_pend;
            end
            // enable survives a bus reset and gates all replies at once
            if (wr_ok && wa == OFS_ADDR)
                function_enable_bit <= wd[ADDR_EN_BIT];
        end
    end

    // ****************************************
    // mode, soft reset, write lock
    // ****************************************
    logic susp_prev;

    always_ff @(posedge clock)
    begin
        if (!resetn)
            soft_reset_pulse <= 1'b0;
        else
            soft_reset_pulse <= wr_ok && wa == OFS_MODE && mode_control[MODE_SFRESET]
                                && !wd[MODE_SFRESET];
    end

    always_ff @(posedge clock)
    begin
        if (rst_all)
            mode_control <= RST_MODE;
        else if (usb_bus_reset)
            mode_control <= mode_control & MODE_BUS_KEEP;
        else if (wr_ok && wa == OFS_MODE)
            mode_control <= wd & MODE_WMASK;
        mode_control[MODE_VBUS_BIT] <= vbus_s2;
    end

    always_ff @(posedge clock)
    begin
        if (rst_all)
        begin
            susp_prev    <= 1'b0;
            write_locked <= 1'b0;
        end
        else
        begin
            susp_prev <= suspend_active;
            // entering suspend wins over an unlock in the same cycle
            if (suspend_active && !susp_prev)
                write_locked <= 1'b1;
            else if (wr_ev && wa == OFS_UNLOCK)
                write_locked <= 1'b0;
        end
    end

    // ****************************************
    // endpoint indexed registers
    // ****************************************
    logic [7:0]          ep_select;
    logic [EP_IDX_W-1:0] ep;
    logic [15:0]         ep_maxpkt  [EP_N];
    logic [15:0]         ep_kind    [EP_N];
    logic [15:0]         ep_count   [EP_N];
    logic [15:0]         ep_fifo    [EP_N];
    logic [7:0]          ep_state   [EP_N];
    logic [7:0]          ep_actions [EP_N];

    assign ep = ep_select[EP_IDX_W-1:0];

    always_ff @(posedge clock)
    begin
        if (rst_all)
        begin
            for (int i = 0; i < EP_N; i++)
            begin
                ep_maxpkt[i]  <= '0;
                ep_kind[i]    <= '0;
                ep_count[i]   <= '0;
                ep_fifo[i]    <= '0;
                ep_state[i]   <= '0;
                ep_actions[i] <= '0;
            end
        end
        else if (wr_ok)
        begin
            case (wa)
                OFS_EP_MAXPKT:  ep_maxpkt[ep]  <= wd;
                OFS_EP_KIND:    ep_kind[ep]    <= wd;
                OFS_EP_COUNT:   ep_count[ep]   <= wd;
                OFS_EP_FIFO:    ep_fifo[ep]    <= wd;
                OFS_EP_STATE:   ep_state[ep]   <= wd[7:0];
                OFS_EP_ACTIONS: ep_actions[ep] <= wd[7:0];
                default:        ;
            endcase
        end
    end

    // ****************************************
    // plain storage registers
    // ****************************************
    logic [7:0]  irq_setup;
    logic [7:0]  session;
    logic [31:0] irq_mask;
    logic [31:0] irq_flags;
    logic [31:0] irq_clr;
    logic [31:0] dma_count;
    logic [15:0] dma_setup;
    logic [7:0]  dma_pins;
    logic [15:0] dma_cause;
    logic [15:0] dma_mask;
    logic [7:0]  dma_ep;
    logic [15:0] dma_burst;
    logic [7:0]  test_ctl;
    logic [15:0] scratch;
    logic [15:0] frame;

    always_ff @(posedge clock)
    begin
        if (rst_all)
        begin
            ep_select <= '0;
            irq_setup <= '0;
            session   <= '0;
            irq_mask  <= '0;
            dma_count <= '0;
            dma_setup <= '0;
            dma_pins  <= '0;
            dma_cause <= '0;
            dma_mask  <= '0;
            dma_ep    <= '0;
            dma_burst <= '0;
            test_ctl  <= '0;
            scratch   <= '0;
        end
        else if (wr_ok)
        begin
            // byte registers keep only the low lane
            case (wa)
                OFS_EP_SELECT:          ep_select <= wd[7:0];
                OFS_IRQ_SETUP:          irq_setup <= wd[7:0];
                OFS_SESSION:            session   <= wd[7:0];
                OFS_IRQ_MASK:           irq_mask  <= put_half(irq_mask, 1'b0, wd);
                OFS_IRQ_MASK + OFS_HI:  irq_mask  <= put_half(irq_mask, 1'b1, wd);
                OFS_DMA_COUNT:          dma_count <= put_half(dma_count, 1'b0, wd);
                OFS_DMA_COUNT + OFS_HI: dma_count <= put_half(dma_count, 1'b1, wd);
                OFS_DMA_SETUP:          dma_setup <= wd;
                OFS_DMA_PINS:           dma_pins  <= wd[7:0];
                OFS_DMA_CAUSE:          dma_cause <= wd;
                OFS_DMA_MASK:           dma_mask  <= wd;
                OFS_DMA_EP:             dma_ep    <= wd[7:0];
                OFS_DMA_BURST:          dma_burst <= wd;
                OFS_TEST:               test_ctl  <= wd[7:0];
                OFS_SCRATCH:            scratch   <= wd;
                default:                ;
            endcase
        end
    end

    always_comb
    begin
        irq_clr = '0;
        if (wr_ok && wa == OFS_IRQ_FLAGS)
            irq_clr = put_half('0, 1'b0, wd);
        else if (wr_ok && wa == OFS_IRQ_FLAGS + OFS_HI)
            irq_clr = put_half('0, 1'b1, wd);
    end

    // write one to clear; a new event in the clearing cycle still sets
    always_ff @(posedge clock)
    begin
        if (rst_all)
            irq_flags <= '0;
        else
            irq_flags <= (irq_flags & ~irq_clr) | irq_events;
    end

    always_ff @(posedge clock)
    begin
        if (rst_all)
            frame <= '0;
        else if (sof_valid)
            frame <= {5'h00, sof_frame};
    end

    // ****************************************
    // read path
    // ****************************************
    logic [15:0] next_rdata;

    always_comb
    begin
        next_rdata = '0;
        case (wa)
            OFS_ADDR:               next_rdata = {8'h00, function_enable_bit, addr_pend};
            OFS_EP_MAXPKT:          next_rdata = ep_maxpkt[ep];
            OFS_EP_KIND:            next_rdata = ep_kind[ep];
            OFS_MODE:               next_rdata = mode_control;
            OFS_IRQ_SETUP:          next_rdata = {8'h00, irq_setup};
            OFS_SESSION:            next_rdata = {8'h00, session};
            OFS_IRQ_MASK:           next_rdata = irq_mask[15:0];
            OFS_IRQ_MASK + OFS_HI:  next_rdata = irq_mask[31:16];
            OFS_IRQ_FLAGS:          next_rdata = irq_flags[15:0];
            OFS_IRQ_FLAGS + OFS_HI: next_rdata = irq_flags[31:16];
            OFS_EP_COUNT:           next_rdata = ep_count[ep];
            OFS_EP_STATE:           next_rdata = {8'h00, ep_state[ep]};
            OFS_EP_FIFO:            next_rdata = ep_fifo[ep];
            OFS_EP_ACTIONS:         next_rdata = {8'h00, ep_actions[ep]};
            OFS_EP_SELECT:          next_rdata = {8'h00, ep_select};
            OFS_DMA_COUNT:          next_rdata = dma_count[15:0];
            OFS_DMA_COUNT + OFS_HI: next_rdata = dma_count[31:16];
            OFS_DMA_SETUP:          next_rdata = dma_setup;
            OFS_DMA_PINS:           next_rdata = {8'h00, dma_pins};
            OFS_DMA_CAUSE:          next_rdata = dma_cause;
            OFS_DMA_MASK:           next_rdata = dma_mask;
            OFS_DMA_EP:             next_rdata = {8'h00, dma_ep};
            OFS_DMA_BURST:          next_rdata = dma_burst;
            OFS_PART_ID:            next_rdata = PART_IDENTIFICATION[15:0];
            OFS_PART_ID + OFS_HI:   next_rdata = {8'h00, PART_IDENTIFICATION[23:16]};
            OFS_FRAME:              next_rdata = frame;
            OFS_SCRATCH:            next_rdata = scratch;
            OFS_TEST:               next_rdata = {8'h00, test_ctl};
            default:                next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            bus_data_out  <= '0;
            bus_data_oe_n <= 1'b1;
        end
        else
        begin
            bus_data_out  <= rd_act ? next_rdata : '0;
            bus_data_oe_n <= ~rd_act;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_unmapped_read;
        rd_act && wa == 8'h40 |=> bus_data_out == 16'h0000 && !bus_data_oe_n;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_bus_reset_addr;
        usb_bus_reset |=> usb_address_field == 7'h00 && addr_pend == 7'h00;
    endproperty
    a_bus_reset_addr: assert property (p_bus_reset_addr)
        else $error("bus reset left address");

    property p_enable_kept;
        usb_bus_reset && !soft_reset_pulse && !(wr_ok && wa == OFS_ADDR)
            |=> $stable(function_enable_bit);
    endproperty
    a_enable_kept: assert property (p_enable_kept)
        else $error("bus reset changed enable");

    property p_soft_clear;
        soft_reset_pulse |=> !function_enable_bit && usb_address_field == 7'h00;
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset left enable");

    property p_addr_defer;
        !status_ack && !usb_bus_reset && !soft_reset_pulse |=> $stable(usb_address_field);
    endproperty
    a_addr_defer: assert property (p_addr_defer)
        else $error("address changed before ack");

    property p_addr_switch;
        status_ack && !usb_bus_reset && !soft_reset_pulse
            |=> usb_address_field == $past(addr_pend);
    endproperty
    a_addr_switch: assert property (p_addr_switch)
        else $error("address not taken at ack");

    property p_locked;
        write_locked && wr_ev && wa == OFS_SCRATCH && !soft_reset_pulse
            |=> $stable(scratch);
    endproperty
    a_locked: assert property (p_locked)
        else $error("write passed while locked");

    property p_unlock;
        wr_ev && wa == OFS_UNLOCK && !(suspend_active && !susp_prev) |=> !write_locked;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock failed");

    property p_ep_write;
        wr_ok && wa == OFS_EP_MAXPKT && !soft_reset_pulse
            |=> ep_maxpkt[$past(ep)] == $past(wd);
    endproperty
    a_ep_write: assert property (p_ep_write)
        else $error("endpoint write misplaced");

    property p_scratch_read;
        rd_act && wa == OFS_SCRATCH |=> bus_data_out == $past(scratch);
    endproperty
    a_scratch_read: assert property (p_scratch_read)
        else $error("scratch read wrong");

endmodule

// ---- udr_pkg.sv ----
// Behaviour
// - every host access is one 16-bit word
// - per-endpoint registers follow the endpoint select
// - address field cleared by any reset
// - enable cleared by power/soft reset only
// - enable low means no answer to host
// - new address active only at status ack
// - bits 6..0 hold the matched device address
// - frame number holds last good frame start
// - unlock write restores writes blocked in suspend
// - two-byte scratch survives suspend
// - read-only three-byte identification register
package udr_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_ADDR       = 8'h00;
    localparam logic [7:0] OFS_EP_MAXPKT  = 8'h04;
    localparam logic [7:0] OFS_EP_KIND    = 8'h08;
    localparam logic [7:0] OFS_MODE       = 8'h0c;
    localparam logic [7:0] OFS_IRQ_SETUP  = 8'h10;
    localparam logic [7:0] OFS_SESSION    = 8'h12;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h18;
    localparam logic [7:0] OFS_EP_COUNT   = 8'h1c;
    localparam logic [7:0] OFS_EP_STATE   = 8'h1e;
    localparam logic [7:0] OFS_EP_FIFO    = 8'h20;
    localparam logic [7:0] OFS_EP_ACTIONS = 8'h28;
    localparam logic [7:0] OFS_EP_SELECT  = 8'h2c;
    localparam logic [7:0] OFS_DMA_CMD    = 8'h30;
    localparam logic [7:0] OFS_DMA_COUNT  = 8'h34;
    localparam logic [7:0] OFS_DMA_SETUP  = 8'h38;
    localparam logic [7:0] OFS_DMA_PINS   = 8'h3c;
    localparam logic [7:0] OFS_DMA_CAUSE  = 8'h50;
    localparam logic [7:0] OFS_DMA_MASK   = 8'h54;
    localparam logic [7:0] OFS_DMA_EP     = 8'h58;
    localparam logic [7:0] OFS_DMA_BURST  = 8'h64;
    localparam logic [7:0] OFS_PART_ID    = 8'h70;
    localparam logic [7:0] OFS_FRAME      = 8'h74;
    localparam logic [7:0] OFS_SCRATCH    = 8'h78;
    localparam logic [7:0] OFS_UNLOCK     = 8'h7c;
    localparam logic [7:0] OFS_TEST       = 8'h84;
    localparam logic [7:0] OFS_HI         = 8'h02;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int          ADDR_EN_BIT     = 7;
    localparam int          MODE_SFRESET    = 4;
    localparam int          MODE_VBUS_BIT   = 8;
    localparam logic [15:0] MODE_WMASK      = 16'h02ff;
    localparam logic [15:0] MODE_BUS_KEEP   = 16'h0009;
    localparam logic [7:0]  RST_ADDR        = 8'h00;
    localparam logic [15:0] RST_MODE        = 16'h0000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
        logic        cs;
        logic        rd;
        logic        wr;
    } udr_bus_t;

endpackage

// ---- udr_host_model.sv ----
`timescale 1ns/100ps
// ****************************************
// host processor model on the parallel bus
// ****************************************
module udr_host_model
(
    input  wire logic        clock,
    output logic             bus_cs_n,
    output logic             bus_rd_n,
    output logic             bus_wr_n,
    output logic [7:0]       bus_addr,
    output logic [15:0]      bus_data_in,
    input  wire logic [15:0] bus_data_out,
    input  wire logic        bus_data_oe_n
);

    initial
    begin
        bus_cs_n    = 1'b1;
        bus_rd_n    = 1'b1;
        bus_wr_n    = 1'b1;
        bus_addr    = 8'h00;
        bus_data_in = 16'h0000;
    end

    // lines left undriven float: show the inverse so stale values never look valid
    task automatic release_bus();
        bus_cs_n    <= 1'b1;
        bus_rd_n    <= 1'b1;
        bus_wr_n    <= 1'b1;
        bus_addr    <= ~bus_addr;
        bus_data_in <= ~bus_data_in;
        repeat (6) @(negedge clock);
    endtask

    // strobe held low five clocks, well over the two the synchroniser needs
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        bus_addr    <= a;
        bus_data_in <= d;
        bus_cs_n    <= 1'b0;
        bus_wr_n    <= 1'b0;
        repeat (5) @(negedge clock);
        release_bus();
    endtask

    // a read that never sees the drive enable returns unknown, so the compare fails
    task automatic read_word(input logic [7:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(negedge clock);
        bus_addr <= a;
        bus_cs_n <= 1'b0;
        bus_rd_n <= 1'b0;
        @(negedge clock);
        while (bus_data_oe_n !== 1'b0 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        d = (n < 20) ? bus_data_out : 16'hxxxx;
        repeat (2) @(negedge clock);
        release_bus();
    endtask

endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb
    import udr_pkg::*;
;
    localparam logic [23:0] ID_VAL = 24'h3c71a2;  // arbitrary value

    logic        clock;
    logic        resetn;
    logic        bus_cs_n;
    logic        bus_rd_n;
    logic        bus_wr_n;
    logic [7:0]  bus_addr;
    logic [15:0] bus_data_in;
    logic        vbus_pin;
    logic        usb_bus_reset;
    logic        status_ack;
    logic        suspend_active;
    logic        sof_valid;
    logic [10:0] sof_frame;
    logic [31:0] irq_events;
    logic [15:0] bus_data_out;
    logic        bus_data_oe_n;
    logic [6:0]  usb_address_field;
    logic        function_enable_bit;
    logic [15:0] mode_control;
    logic        write_locked;
    logic        soft_reset_pulse;
    logic [15:0] rdat;
    int          err_total;
    int          samples_checked;

    always #10 clock = ~clock;

    udr_host_model u_host (
        .clock         (clock),
        .bus_cs_n      (bus_cs_n),
        .bus_rd_n      (bus_rd_n),
        .bus_wr_n      (bus_wr_n),
        .bus_addr      (bus_addr),
        .bus_data_in   (bus_data_in),
        .bus_data_out  (bus_data_out),
        .bus_data_oe_n (bus_data_oe_n)
    );

    udr_register_map #(.EP_IDX_W(5), .PART_IDENTIFICATION(ID_VAL)) u_dut (
        .clock               (clock),
        .resetn              (resetn),
        .bus_cs_n            (bus_cs_n),
        .bus_rd_n            (bus_rd_n),
        .bus_wr_n            (bus_wr_n),
        .bus_addr            (bus_addr),
        .bus_data_in         (bus_data_in),
        .vbus_pin            (vbus_pin),
        .usb_bus_reset       (usb_bus_reset),
        .status_ack          (status_ack),
        .suspend_active      (suspend_active),
        .sof_valid           (sof_valid),
        .sof_frame           (sof_frame),
        .irq_events          (irq_events),
        .bus_data_out        (bus_data_out),
        .bus_data_oe_n       (bus_data_oe_n),
        .usb_address_field   (usb_address_field),
        .function_enable_bit (function_enable_bit),
        .mode_control        (mode_control),
        .write_locked        (write_locked),
        .soft_reset_pulse    (soft_reset_pulse)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.write_word(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        u_host.read_word(a, rdat);
        check(rdat, exp);
    endtask

    task automatic ack_status();
        status_ack <= 1'b1;
        tick(1);
        status_ack <= 1'b0;
        tick(1);
    endtask

    task automatic check_addr(input logic en, input logic [6:0] adr);
        check({15'h0000, function_enable_bit}, {15'h0000, en});
        check({9'h000, usb_address_field}, {9'h000, adr});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_unmapped();
        wr(8'h40, 16'hbeef);
        rd_chk(8'h40, 16'h0000);
        rd_chk(8'h90, 16'h0000);
    endtask

    task automatic t_address();
        check_addr(1'b0, 7'h00);
        wr(OFS_ADDR, 16'h0085);
        check_addr(1'b1, 7'h00);
        rd_chk(OFS_ADDR, 16'h0085);
        ack_status();
        check_addr(1'b1, 7'h05);
        usb_bus_reset <= 1'b1;
        tick(1);
        usb_bus_reset <= 1'b0;
        tick(2);
        check_addr(1'b1, 7'h00);
        rd_chk(OFS_ADDR, 16'h0080);
    endtask

    task automatic t_endpoints();
        logic [7:0] ofs [3];
        ofs = '{OFS_EP_MAXPKT, OFS_EP_KIND, OFS_EP_COUNT};
        foreach (ofs[i])
        begin
            wr(OFS_EP_SELECT, 16'h0001);
            wr(ofs[i], 16'(16'h0004 + i));
            wr(OFS_EP_SELECT, 16'h0002);
            wr(ofs[i], 16'(16'h0008 + i));
            rd_chk(ofs[i], 16'(16'h0008 + i));
            wr(OFS_EP_SELECT, 16'h0001);
            rd_chk(ofs[i], 16'(16'h0004 + i));
        end
    endtask

    task automatic t_suspend();
        wr(OFS_SCRATCH, 16'ha55a);
        suspend_active <= 1'b1;
        tick(2);
        check({15'h0000, write_locked}, 16'h0001);
        wr(OFS_SCRATCH, 16'h1234);
        rd_chk(OFS_SCRATCH, 16'ha55a);
        wr(OFS_UNLOCK, 16'h0000);
        check({15'h0000, write_locked}, 16'h0000);
        wr(OFS_SCRATCH, 16'h1234);
        rd_chk(OFS_SCRATCH, 16'h1234);
        suspend_active <= 1'b0;
    endtask

    task automatic t_ident_frame();
        rd_chk(OFS_PART_ID, ID_VAL[15:0]);
        rd_chk(OFS_PART_ID + OFS_HI, {8'h00, ID_VAL[23:16]});
        wr(OFS_PART_ID, 16'h0000);
        rd_chk(OFS_PART_ID, ID_VAL[15:0]);
        sof_frame <= 11'h5a3;
        sof_valid <= 1'b1;
        tick(1);
        sof_valid <= 1'b0;
        sof_frame <= 11'h2c1;
        tick(2);
        rd_chk(OFS_FRAME, 16'h05a3);
    endtask

    task automatic t_wide_regs();
        rd_chk(OFS_MODE, 16'h0100);
        irq_events <= 32'h0001_0002;
        tick(1);
        irq_events <= 32'h0000_0000;
        tick(2);
        rd_chk(OFS_IRQ_FLAGS, 16'h0002);
        rd_chk(OFS_IRQ_FLAGS + OFS_HI, 16'h0001);
        wr(OFS_IRQ_FLAGS, 16'h0002);
        rd_chk(OFS_IRQ_FLAGS, 16'h0000);
    endtask

    task automatic t_resets();
        wr(OFS_ADDR, 16'h0083);
        ack_status();
        check_addr(1'b1, 7'h03);
        wr(OFS_SCRATCH, 16'h00c3);
        wr(OFS_MODE, 16'h0010);
        check(mode_control, 16'h0110);
        check({15'h0000, soft_reset_pulse}, 16'h0000);
        check_addr(1'b1, 7'h03);
        wr(OFS_MODE, 16'h0000);
        check(mode_control, 16'h0100);
        check_addr(1'b0, 7'h00);
        rd_chk(OFS_ADDR, 16'h0000);
        rd_chk(OFS_SCRATCH, 16'h0000);
        wr(OFS_ADDR, 16'h0086);
        ack_status();
        check_addr(1'b1, 7'h06);
        resetn <= 1'b0;
        tick(3);
        resetn <= 1'b1;
        tick(4);
        check_addr(1'b0, 7'h00);
        rd_chk(OFS_ADDR, 16'h0000);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        clock           = 1'b0;
        resetn          = 1'b0;
        vbus_pin        = 1'b1;
        usb_bus_reset   = 1'b0;
        status_ack      = 1'b0;
        suspend_active  = 1'b0;
        sof_valid       = 1'b0;
        sof_frame       = 11'h000;
        irq_events      = 32'h0000_0000;
        err_total       = 0;
        samples_checked = 0;
        tick(12);
        resetn <= 1'b1;
        tick(4);
        t_unmapped();
        t_address();
        t_endpoints();
        t_suspend();
        t_ident_frame();
        t_wide_regs();
        t_resets();
        print_verdict();
    end

    // whole run is under a thousand clocks; five times that means a hang
    initial
    begin
        #100000;
        err_total++;
        print_verdict();
    end

endmodule
